// [pps_pkg.sv]
// Constants shared by the push-pull pulse steering block.
// Assumes a single 125 MHz clock and times expressed in microseconds.
`default_nettype none

package pps_pkg;

  // ==========================================================
  // Clock rate and widths.
  // ==========================================================
  localparam int unsigned CLK_MHZ  = 125;
  localparam int unsigned WIDTH_W  = 12;
  localparam int unsigned CNT_W    = 12;

  // ==========================================================
  // Timing figures in microseconds.
  // ==========================================================
  localparam int unsigned MAX_PULSE_US = 20;
  localparam int unsigned DEAD_US      = 5;

  // Longest time rounds down, least time rounds up, neither below one cycle.
  localparam int unsigned MAX_PULSE_CYC_I = (MAX_PULSE_US * CLK_MHZ < 1) ? 1 :
                                            MAX_PULSE_US * CLK_MHZ;
  localparam int unsigned DEAD_CYC_I      = (DEAD_US * CLK_MHZ < 1) ? 1 :
                                            DEAD_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] MAX_PULSE_CYC = CNT_W'(MAX_PULSE_CYC_I);
  localparam logic [CNT_W-1:0] DEAD_CYC      = CNT_W'(DEAD_CYC_I);

  // ==========================================================
  // Reset values and small constants.
  // ==========================================================
  localparam logic [CNT_W-1:0]   CNT_ZERO   = 12'h000;
  localparam logic [CNT_W-1:0]   CNT_ONE    = 12'h001;
  localparam logic [WIDTH_W-1:0] WIDTH_ONE  = 12'h001;
  localparam logic               PHASE_RST  = 1'h0;
  localparam logic               CTRL_IDLE  = 1'h1;

  // One-shot state.
  typedef enum logic {PPS_OS_IDLE, PPS_OS_RUN} pps_os_state_t;

endpackage

`default_nettype wire

// [pps_os_if.sv]
// Carrier between the steering logic and its width-control one-shot.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface pps_os_if;
  logic                        start;   // One-cycle start or retrigger.
  logic [pps_pkg::WIDTH_W-1:0] width;   // Width command in clock cycles.
  logic                        ctrl;    // Control output, low while pulse runs.

  modport shot (input start, input width, output ctrl);
  modport user (output start, output width, input ctrl);
endinterface : pps_os_if

`default_nettype wire

// [pps_one_shot.sv]
// Width-control one-shot: a start drives the control low until the
// accumulated count reaches the width command or the hard limit.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pps_one_shot (
  // Clock and reset.
  input  wire logic  i_mclk,
  input  wire logic  i_rst,
  // Link to the steering logic.
  pps_os_if.shot     os
);

  pps_pkg::pps_os_state_t       state_q;
  logic [pps_pkg::CNT_W-1:0]    acc_q;
  logic [pps_pkg::WIDTH_W-1:0]  thr;
  logic                         end_now;

  // ==========================================================
  // Threshold: width command clipped to one cycle and the hard limit.
  // ==========================================================
  always_comb begin
    thr = os.width;
    if (os.width < pps_pkg::WIDTH_ONE) begin
      thr = pps_pkg::WIDTH_ONE;
    end
    if (os.width > pps_pkg::MAX_PULSE_CYC) begin
      thr = pps_pkg::MAX_PULSE_CYC;
    end
    end_now = ((acc_q + pps_pkg::CNT_ONE) >= thr);
  end

  // ==========================================================
  // Pulse state: started by every start, ended by the threshold.
  // ==========================================================
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= pps_pkg::PPS_OS_IDLE;
      acc_q   <= pps_pkg::CNT_ZERO;
    end else begin
      case (state_q)
        pps_pkg::PPS_OS_IDLE: begin
          acc_q <= pps_pkg::CNT_ZERO;
          if (os.start) begin
            state_q <= pps_pkg::PPS_OS_RUN;
          end
        end
        pps_pkg::PPS_OS_RUN: begin
          if (os.start) begin
            acc_q <= pps_pkg::CNT_ZERO;        // Retrigger restarts timing.
          end else if (end_now) begin
            state_q <= pps_pkg::PPS_OS_IDLE;
            acc_q   <= pps_pkg::CNT_ZERO;
          end else begin
            acc_q <= acc_q + pps_pkg::CNT_ONE;
          end
        end
        default: begin
          state_q <= pps_pkg::PPS_OS_IDLE;
          acc_q   <= pps_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // Control is high while idle and low while the pulse runs.
  assign os.ctrl = (state_q == pps_pkg::PPS_OS_IDLE);

  // ==========================================================
  // Checks.
  // ==========================================================
  hard_limit_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !os.ctrl |-> (acc_q < pps_pkg::MAX_PULSE_CYC))
    else $error("One-shot ran past the hard limit.");

  end_at_thr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!os.ctrl && !os.start && end_now) |=> os.ctrl)
    else $error("One-shot did not end at its threshold.");

endmodule // pps_one_shot

`default_nettype wire

// [pps_steer.sv]
// Push-pull pulse steering: a toggling phase selector and a width-control
// one-shot gate two drive outputs, with a hard width limit and dead time.
// Assumes i_osc and i_width are synchronous to i_mclk; the oscillator
// period should exceed the longest pulse plus the dead time.
//
// Function
// - Phase selector flip-flop feeds its inverted output back, toggling on each oscillator rising edge.
// - Each oscillator rising edge toggles phase and starts a one-shot pulse.
// - One-shot ends when its count reaches the width command threshold.
// - A drive is high only while control and its phase signal are low.
// - Only one phase is ever low, so drives never assert together.
// - One-shot pulse is forced to end 20 us after it starts.
// - Control gates both drives, ending the active one at pulse end.
// - Control low with phase low asserts the first drive.
// - Next period, control low with phase high asserts the second drive.
// - At least 5 us with both drives off between opposite pulses.
`timescale 1ns/1ps
`default_nettype none

module pps_steer (
  // Clock and reset.
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  // Free-running oscillator and width command from the feedback loop.
  input  wire logic                        i_osc,
  input  wire logic [pps_pkg::WIDTH_W-1:0] i_width,
  // Drive outputs to the transistor drivers, active high.
  output var  logic                        o_drive_a,
  output var  logic                        o_drive_b,
  // Observation of internal state.
  output var  logic                        o_phase,
  output var  logic                        o_ctrl
);

  pps_os_if os ();

  logic                      osc_q;
  logic                      edge_s;
  logic                      phase_q;
  logic                      phase_d;
  logic                      allow_q;
  logic [pps_pkg::CNT_W-1:0] dead_q;
  logic                      dead_ok;
  logic                      drive_a_q;
  logic                      drive_a_d;
  logic                      drive_b_q;
  logic                      drive_b_d;
  logic                      ctrl_q;

  // ==========================================================
  // Oscillator edge detect.
  // ==========================================================
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      osc_q <= 1'h0;
    end else begin
      osc_q <= i_osc;
    end
  end

  // A rising edge is a high level that was low one cycle earlier.
  assign edge_s = i_osc & ~osc_q;

  // ==========================================================
  // Phase selector.
  // ==========================================================
  // inverted output feedback.
  assign phase_d = ~phase_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= pps_pkg::PHASE_RST;              // clear phase.
    end else if (edge_s) begin
      phase_q <= phase_d;
    end
  end

  // ==========================================================
  // Width-control one-shot.
  // ==========================================================
  // start the one-shot.
  assign os.start = edge_s;
  assign os.width = i_width;

  pps_one_shot u_shot (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .os     (os.shot)
  );

  // ==========================================================
  // Dead-time timer: counts cycles with both drives off.
  // ==========================================================
  assign dead_ok = (dead_q >= pps_pkg::DEAD_CYC);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dead_q <= pps_pkg::DEAD_CYC;                // Start with dead time met.
    end else if (drive_a_q || drive_b_q) begin
      dead_q <= pps_pkg::CNT_ZERO;
    end else if (!dead_ok) begin
      dead_q <= dead_q + pps_pkg::CNT_ONE;
    end
  end

  // Each pulse may drive only if the dead time was met when it started.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      allow_q <= 1'h0;
    end else if (edge_s) begin
      allow_q <= dead_ok & ~(drive_a_q | drive_b_q);
    end
  end

  // ==========================================================
  // Output gates.
  // ==========================================================
  always_comb begin
    drive_a_d = ~os.ctrl & ~phase_q & allow_q;
    drive_b_d = ~os.ctrl &  phase_q & allow_q;
  end

  // Registered drives and observation outputs.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      drive_a_q <= 1'h0;                          // drives low.
      drive_b_q <= 1'h0;
      ctrl_q    <= pps_pkg::CTRL_IDLE;
    end else begin
      drive_a_q <= drive_a_d;
      drive_b_q <= drive_b_d;
      ctrl_q    <= os.ctrl;
    end
  end

  assign o_drive_a = drive_a_q;
  assign o_drive_b = drive_b_q;
  assign o_phase   = phase_q;
  assign o_ctrl    = ctrl_q;

  // ==========================================================
  // Checks: helper counters.
  // ==========================================================
  logic [pps_pkg::CNT_W-1:0] low_run_q;   // Cycles the registered control is low.
  logic [pps_pkg::CNT_W-1:0] off_run_q;   // Cycles both drives are off.
  logic                      last_b_q;    // Which drive was high last.

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      low_run_q <= pps_pkg::CNT_ZERO;
      off_run_q <= pps_pkg::DEAD_CYC;
      last_b_q  <= 1'h0;
    end else begin
      low_run_q <= ctrl_q ? pps_pkg::CNT_ZERO : low_run_q + pps_pkg::CNT_ONE;
      if (drive_a_q || drive_b_q) begin
        off_run_q <= pps_pkg::CNT_ZERO;
        last_b_q  <= drive_b_q;
      end else if (off_run_q < pps_pkg::DEAD_CYC) begin
        off_run_q <= off_run_q + pps_pkg::CNT_ONE;
      end
    end
  end

  // A pulse starts one cycle after the edge; the limit is checked by max_width_a.
  sequence pulse_start_s;
    edge_s ##1 !os.ctrl;
  endsequence

  // ==========================================================
  // Checks: assertions.
  // ==========================================================
  phase_toggle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    edge_s |=> (phase_q != $past(phase_q)))
    else $error("Phase selector did not toggle on an edge.");

  phase_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !edge_s |=> $stable(phase_q))
    else $error("Phase selector changed without an edge.");

  shot_start_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    edge_s |-> pulse_start_s)
    else $error("One-shot did not start on an edge.");

  gate_inputs_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_drive_a |-> ($past(phase_q) == 1'h0 && $past(os.ctrl) == 1'h0))
    else $error("First drive high without both gate inputs low.");

  drive_excl_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(o_drive_a && o_drive_b))
    else $error("Both drives asserted together.");

  max_width_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    low_run_q <= pps_pkg::MAX_PULSE_CYC)
    else $error("Control stayed low past the hard limit.");

  ctrl_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(os.ctrl) |=> !(o_drive_a || o_drive_b))
    else $error("A drive stayed high after pulse end.");

  second_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!os.ctrl && phase_q && allow_q) |=> (o_drive_b && !o_drive_a))
    else $error("Second drive missing while enabled.");

  dead_gap_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($rose(o_drive_a) && last_b_q) || ($rose(o_drive_b) && !last_b_q)
      |-> ($past(off_run_q) >= pps_pkg::DEAD_CYC))
    else $error("Opposite drive started inside the dead interval.");

endmodule // pps_steer

`default_nettype wire

// [pps_drv_model.sv]
// Model of the two transistor base drivers fed by the steering block.
// Assumes drives are active high and synchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none

module pps_drv_model (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Drive inputs from the steering block.
  input  wire logic        i_drive_a,
  input  wire logic        i_drive_b,
  // Observed conduction history.
  output var  logic [15:0] o_pulses,
  output var  logic        o_overlap
);
  logic on_q;

  // ==========================================================
  // Conduction tracking
  // ==========================================================
  // Counts each start of conduction on either transistor.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      on_q     <= 1'h0;
      o_pulses <= 16'h0000;
    end else begin
      on_q <= i_drive_a | i_drive_b;
      if ((i_drive_a | i_drive_b) && !on_q) begin
        o_pulses <= o_pulses + 16'h0001;
      end
    end
  end

  // shoot-through latch.
  // Latches a fault if both transistors ever conduct together.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_overlap <= 1'h0;
    end else if (i_drive_a && i_drive_b) begin
      o_overlap <= 1'h1;
    end
  end
endmodule // pps_drv_model

`default_nettype wire

// [tb_push_pull_pwm_steering.sv]
// Self-checking bench for the push-pull pulse steering block.
// Assumes the driver model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none

module tb_push_pull_pwm_steering;
  logic                        i_mclk;
  logic                        i_rst;
  logic                        i_osc;
  logic [pps_pkg::WIDTH_W-1:0] i_width;
  logic                        o_drive_a;
  logic                        o_drive_b;
  logic                        o_phase;
  logic                        o_ctrl;
  logic [15:0]                 pulses;
  logic                        overlap;
  logic [31:0]                 rnd;
  logic                        ph_q;
  int                          err_count;
  int                          cmp_count;
  int                          npulse;
  int                          cyc;

  pps_steer u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_osc(i_osc), .i_width(i_width),
    .o_drive_a(o_drive_a), .o_drive_b(o_drive_b), .o_phase(o_phase), .o_ctrl(o_ctrl));

  pps_drv_model u_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_drive_a(o_drive_a),
    .i_drive_b(o_drive_b), .o_pulses(pulses), .o_overlap(overlap));

  // ==========================================================
  // Clock, timeout and helpers
  // ==========================================================
  // Free-running 125 MHz clock.
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // Cuts a hang short well above the expected run length.
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc >= 90000) begin
      err_count = err_count + 1;
      close_out();
    end
  end

  // Repeatable xorshift stream.
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  // Pulse length expected for a width command.
  function automatic int exp_thr(input logic [11:0] w);
    int lim;
    lim = pps_pkg::MAX_PULSE_US * pps_pkg::CLK_MHZ;
    if (w == 12'h000) return 1;
    return (int'(w) > lim) ? lim : int'(w);
  endfunction

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int g);
    cmp_count = cmp_count + 1;
    if (g != e) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // One oscillator period: raise i_osc for one cycle, then watch both drives.
  task automatic run_period(input logic [11:0] w, input bit on);
    int na, nb, nc, first, lim, thr;
    ph_q = ~ph_q;
    thr = exp_thr(w);
    lim = thr + 8;
    na = 0;
    nb = 0;
    nc = 0;
    first = -1;
    i_osc = 1'b1;
    i_width = w;
    for (int k = 0; k < lim; k++) begin
      @(posedge i_mclk);
      #1;
      i_osc = 1'b0;
      if (o_drive_a === 1'b1) na++;
      if (o_drive_b === 1'b1) nb++;
      if (o_drive_a === 1'b1 && o_drive_b === 1'b1) nc++;
      if ((o_drive_a === 1'b1 || o_drive_b === 1'b1) && first < 0) begin
        first = k;
        chk_bit("o_ctrl", 1'b0, o_ctrl);
      end
    end
    if (on) npulse++;
    chk_bit("o_phase", ph_q, o_phase);
    chk_int("drive_a", (on && !ph_q) ? thr : 0, na);
    chk_int("drive_b", (on && ph_q) ? thr : 0, nb);
    chk_int("both", 0, nc);
    chk_bit("start", on, first >= 1 && first <= 3);
    chk_bit("o_ctrl", 1'b1, o_ctrl);
  endtask

  // Checks the idle state held by reset.
  task automatic chk_idle();
    chk_bit("o_drive_a", 1'b0, o_drive_a);
    chk_bit("o_drive_b", 1'b0, o_drive_b);
    chk_bit("o_phase", 1'b0, o_phase);
    chk_bit("o_ctrl", 1'b1, o_ctrl);
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [11:0] corners [5];
    corners = '{12'h001, 12'h000, 12'h9c4, 12'h9c5, 12'hfff};
    err_count = 0;
    cmp_count = 0;
    npulse = 0;
    cyc = 0;
    rnd = 32'h0000003a;
    ph_q = 1'b0;
    i_rst = 1'b1;
    i_osc = 1'b0;
    i_width = 12'h010;
    idle(10);
    chk_idle();
    i_rst = 1'b0;
    idle(1);
    chk_idle();
    // Boundary widths, including zero and values past the hard limit.
    foreach (corners[i]) begin
      run_period(corners[i], 1'b1);
      idle(650);
    end
    // A start inside the dead interval drives nothing but still toggles.
    run_period(12'h020, 1'b1);
    idle(100);
    run_period(12'h020, 1'b0);
    idle(650);
    run_period(12'h020, 1'b1);
    idle(650);
    // Random width commands as the feedback loop would supply them.
    for (int i = 0; i < 10; i++) begin
      run_period(12'(xs() % 32'd3000), 1'b1);
      idle(650);
    end
    chk_int("pulses", npulse, int'(pulses));
    chk_bit("overlap", 1'b0, overlap);
    // An edge inside a running pulse restarts the count and cuts the drive.
    i_width = 12'h100;
    i_osc = 1'h1;
    idle(1);
    i_osc = 1'h0;
    idle(99);
    chk_bit("drive_on", 1'h1, o_drive_a | o_drive_b);
    i_osc = 1'h1;
    idle(2);
    i_osc = 1'h0;
    chk_bit("drive_cut", 1'h0, o_drive_a | o_drive_b);
    chk_bit("o_phase", ph_q, o_phase);
    idle(250);
    chk_bit("o_ctrl", 1'h0, o_ctrl);
    idle(10);
    chk_bit("o_ctrl", 1'h1, o_ctrl);
    // Mid-run reset returns to the first phase.
    i_rst = 1'b1;
    idle(3);
    chk_idle();
    i_rst = 1'b0;
    ph_q = 1'b0;
    idle(2);
    run_period(12'h040, 1'b1);
    chk_int("pulses", 1, int'(pulses));
    chk_bit("overlap", 1'h0, overlap);
    close_out();
  end
endmodule // tb_push_pull_pwm_steering

`default_nettype wire
